// ---- src/cis_params.svh ----
`ifndef CIS_PARAMS_SVH
`define CIS_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define CIS_OFF_CORE_CTRL   12'h000
`define CIS_OFF_FLAGS_REG   12'h004
`define CIS_OFF_ENABLE      12'h008
`define CIS_OFF_IRQ_FLAGS   12'h00c
`define CIS_OFF_LEVEL_SEL   12'h010
`define CIS_OFF_STATUS      12'h014
`define CIS_OFF_STACK_PTR   12'h018

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CIS_CTRL_VRS_BIT    0
`define CIS_CTRL_APPLK_BIT  1
`define CIS_CTRL_LDRLK_BIT  2
`define CIS_FLG_C_BIT       0
`define CIS_FLG_Z_BIT       1
`define CIS_FLG_I_BIT       7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CIS_RST_CTRL        3'h0
`define CIS_RST_FLAGS       8'h00
`define CIS_RST_ENABLE      8'h00
`define CIS_RST_LEVEL_SEL   8'h00
`define CIS_RST_SP          16'h10ff

// ----------------------------------------------------------------
// Timing counts (core clock cycles)
// ----------------------------------------------------------------
`define CIS_ENTRY_CYCLES    3'h5
`define CIS_WAKE_CYCLES     3'h5
`define CIS_RETURN_CYCLES   3'h5
`define CIS_PC_BYTES        3'h3

`endif

// ---- src/cis_pkg.sv ----
package cis_pkg;

    typedef enum logic [1:0] {
        CIS_ST_RUN    = 2'b00,
        CIS_ST_WAKE   = 2'b01,
        CIS_ST_ENTRY  = 2'b10,
        CIS_ST_RETURN = 2'b11
    } cis_state_e;

    typedef struct packed {
        logic retire;
        logic busy;
        logic sei;
        logic global_disable_instruction;
        logic return_from_handler_instruction;
        logic sleeping;
    } cis_insn_s;

    typedef struct packed {
        logic       valid;
        logic [1:0] op;
        logic [4:0] rd;
        logic [4:0] rr;
    } cis_alu_s;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cis_stack_s;

    typedef struct packed {
        logic        jump;
        logic [23:0] target;
    } cis_redirect_s;

endpackage

// ---- src/cis_sequencer.sv ----
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "cis_params.svh"
// Functional notes
// - Runs on undivided core clock, no divider
// - Two-register ALU op completes in one cycle
// - Reset and each source own vectors
// - Take only with own and global enable
// - Lock bits suppress by program counter region
// - Lower vector index wins; reset highest
// - Relocate bit and fuse move vectors
// - Entry clears global enable
// - Global enable in handler allows nesting
// - Return sets global enable
// - Vectoring clears the matching flag
// - Write one clears flag, zero keeps
// - Disabled flags stay pending, served by priority
// - Level sources request only while present
// - One main instruction after return first
// - Flags register not saved nor restored
// - Global disable blocks same-cycle interrupt
// - Instruction after enable runs before interrupt
// - Entry five cycles, pushes program counter
// - Multi-cycle instruction finishes before entry
// - Wake from sleep adds five cycles
// - Return five cycles, pops three bytes
module cis_sequencer
    import cis_pkg::*;
#(
    parameter int          NSRC        = 8,
    parameter logic [23:0] LOADER_BASE = 24'h00f000
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                clk_en,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire logic [NSRC-1:0]     src_event,
    input  wire logic [NSRC-1:0]     src_level,
    input  wire logic                reset_vector_relocate_fuse,
    input  wire cis_insn_s           insn,
    input  wire logic [23:0]         pc_in,
    input  wire cis_alu_s            alu_req,
    input  wire logic [7:0]          stack_rdata,
    output cis_stack_s               stack_bus,
    output cis_redirect_s            redirect,
    output logic                     entry_busy,
    output logic [7:0]               alu_result,
    output logic [23:0]              reset_vector
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Core clock is pclk itself: no prescaler anywhere in this block
    cis_state_e          state_ff;
    logic [2:0]          cnt_ff;
    logic [2:0]          core_ctrl_ff;
    logic [7:0]          flags_reg_ff;
    logic [NSRC-1:0]     enable_ff;
    logic [NSRC-1:0]     irq_flag_ff;
    logic [NSRC-1:0]     level_sel_ff;
    logic [15:0]         sp_ff;
    logic                hold_one_ff;
    logic                fuse_ff;
    logic                strap_done_ff;
    logic [$clog2(NSRC)-1:0] vec_idx_ff;
    logic [23:0]         ret_pc_ff;
    logic [7:0]          regfile_ff [32];

    logic [NSRC-1:0]     pending;
    logic                locked;
    logic                take;
    logic [$clog2(NSRC)-1:0] win_idx;
    logic                apb_wr;
    logic                apb_rd;
    logic [NSRC-1:0]     w1c;
    logic [NSRC-1:0]     hw_clr;
    logic [8:0]          nxt_alu;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [23:0] vec_addr(input logic relocate, input logic [7:0] slot);
        // Two program words per slot; slot 0 is reset
        vec_addr = (relocate ? LOADER_BASE : 24'h000000) + {15'h0000, slot, 1'b0};
    endfunction

    function automatic logic [$clog2(NSRC)-1:0] first_set(input logic [NSRC-1:0] req);
        first_set = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                first_set = i[$clog2(NSRC)-1:0];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Request qualification
    // ----------------------------------------------------------------
    always_comb begin
        // Level sources have no memory: they vanish with their condition
        pending = ((irq_flag_ff & ~level_sel_ff) | (src_level & level_sel_ff))
                  & enable_ff;
        locked  = (core_ctrl_ff[`CIS_CTRL_APPLK_BIT] && pc_in < LOADER_BASE) ||
                  (core_ctrl_ff[`CIS_CTRL_LDRLK_BIT] && pc_in >= LOADER_BASE);
        win_idx = first_set(pending);
        // Only at an instruction boundary, never mid multi-cycle insn
        take    = (state_ff == CIS_ST_RUN) && (|pending) && !locked &&
                  flags_reg_ff[`CIS_FLG_I_BIT] &&
                  !insn.global_disable_instruction &&
                  !hold_one_ff &&
                  (insn.retire || insn.sleeping) && !insn.busy;
    end

    // ----------------------------------------------------------------
    // Sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= CIS_ST_RUN;
            cnt_ff     <= 3'h0;
            vec_idx_ff <= '0;
        end else if (clk_en) begin
            unique case (state_ff)
                CIS_ST_RUN: begin
                    cnt_ff <= 3'h0;
                    if (take) begin
                        vec_idx_ff <= win_idx;
                        state_ff   <= insn.sleeping ? CIS_ST_WAKE : CIS_ST_ENTRY;
                    end else if (insn.return_from_handler_instruction && insn.retire) begin
                        state_ff <= CIS_ST_RETURN;
                    end
                end
                CIS_ST_WAKE: begin
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == `CIS_WAKE_CYCLES - 3'h1) begin
                        cnt_ff   <= 3'h0;
                        state_ff <= CIS_ST_ENTRY;
                    end
                end
                CIS_ST_ENTRY: begin
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == `CIS_ENTRY_CYCLES - 3'h1) begin
                        cnt_ff   <= 3'h0;
                        state_ff <= CIS_ST_RUN;
                    end
                end
                CIS_ST_RETURN: begin
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == `CIS_RETURN_CYCLES - 3'h1) begin
                        cnt_ff   <= 3'h0;
                        state_ff <= CIS_ST_RUN;
                    end
                end
            endcase
        end
    end

    // One main-program instruction must retire after return or enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_one_ff <= 1'b0;
        end else if (clk_en) begin
            if (state_ff == CIS_ST_RETURN && cnt_ff == `CIS_RETURN_CYCLES - 3'h1) begin
                hold_one_ff <= 1'b1;
            end else if (insn.sei && insn.retire) begin
                hold_one_ff <= 1'b1;
            end else if (insn.retire) begin
                hold_one_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Stack traffic and redirect
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_bus  <= '0;
            sp_ff      <= `CIS_RST_SP;
            redirect   <= '0;
            ret_pc_ff  <= 24'h000000;
        end else if (clk_en) begin
            stack_bus.we <= 1'b0;
            stack_bus.re <= 1'b0;
            redirect     <= '0;
            if (apb_wr && paddr == `CIS_OFF_STACK_PTR) begin
                sp_ff <= pwdata[15:0];
            end
            // Push low byte first, stack grows downward
            if (state_ff == CIS_ST_ENTRY && cnt_ff < `CIS_PC_BYTES) begin
                stack_bus.we    <= 1'b1;
                stack_bus.addr  <= sp_ff;
                stack_bus.wdata <= pc_in[{cnt_ff[1:0], 3'b000} +: 8];
                sp_ff           <= sp_ff - 16'h0001;
            end
            if (state_ff == CIS_ST_ENTRY && cnt_ff == `CIS_ENTRY_CYCLES - 3'h1) begin
                redirect.jump   <= 1'b1;
                redirect.target <= vec_addr(core_ctrl_ff[`CIS_CTRL_VRS_BIT],
                                            8'({1'b0, vec_idx_ff} + 1));
            end
            // Pop high byte first; data comes back one cycle later
            if (state_ff == CIS_ST_RETURN && cnt_ff < `CIS_PC_BYTES) begin
                stack_bus.re   <= 1'b1;
                stack_bus.addr <= sp_ff + 16'h0001;
                sp_ff          <= sp_ff + 16'h0001;
            end
            // Each byte stands one cycle after the cycle of its read strobe
            if (state_ff == CIS_ST_RETURN && cnt_ff >= 3'h2 &&
                cnt_ff <= `CIS_PC_BYTES + 3'h1) begin
                ret_pc_ff <= {ret_pc_ff[15:0], stack_rdata};
            end
            // Last byte arrives on the jump cycle itself, so it bypasses the shifter
            if (state_ff == CIS_ST_RETURN && cnt_ff == `CIS_RETURN_CYCLES - 3'h1) begin
                redirect.jump   <= 1'b1;
                redirect.target <= {ret_pc_ff[15:0], stack_rdata};
            end
        end
    end

    assign entry_busy = (state_ff != CIS_ST_RUN);

    // ----------------------------------------------------------------
    // Reset vector strap, caught after release
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_ff       <= 1'b0;
            strap_done_ff <= 1'b0;
        end else if (clk_en && !strap_done_ff) begin
            fuse_ff       <= reset_vector_relocate_fuse;
            strap_done_ff <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_vector <= 24'h000000;
        end else if (clk_en) begin
            reset_vector <= vec_addr(fuse_ff, 8'h00);
        end
    end

    // ----------------------------------------------------------------
    // Flags register and interrupt flags
    // ----------------------------------------------------------------
    // Handlers must save flags themselves: nothing here stacks them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg_ff <= `CIS_RST_FLAGS;
        end else if (clk_en) begin
            if (apb_wr && paddr == `CIS_OFF_FLAGS_REG) begin
                flags_reg_ff <= pwdata[7:0];
            end
            if (alu_req.valid) begin
                flags_reg_ff[`CIS_FLG_C_BIT] <= nxt_alu[8];
                flags_reg_ff[`CIS_FLG_Z_BIT] <= (nxt_alu[7:0] == 8'h00);
            end
            if (insn.sei && insn.retire) begin
                flags_reg_ff[`CIS_FLG_I_BIT] <= 1'b1;
            end
            if (insn.global_disable_instruction) begin
                flags_reg_ff[`CIS_FLG_I_BIT] <= 1'b0;
            end
            if (take) begin
                flags_reg_ff[`CIS_FLG_I_BIT] <= 1'b0;
            end
            if (state_ff == CIS_ST_RETURN && cnt_ff == `CIS_RETURN_CYCLES - 3'h1) begin
                flags_reg_ff[`CIS_FLG_I_BIT] <= 1'b1;
            end
        end
    end

    always_comb begin
        w1c    = (apb_wr && paddr == `CIS_OFF_IRQ_FLAGS) ? pwdata[NSRC-1:0] : '0;
        hw_clr = '0;
        if (take) begin
            hw_clr[win_idx] = 1'b1;
        end
    end

    // A new event beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_ff <= '0;
        end else if (clk_en) begin
            irq_flag_ff <= (irq_flag_ff & ~w1c & ~hw_clr) | src_event;
        end
    end

    // ----------------------------------------------------------------
    // Single-cycle register-to-register ALU
    // ----------------------------------------------------------------
    always_comb begin
        unique case (alu_req.op)
            2'b00: nxt_alu = {1'b0, regfile_ff[alu_req.rd]} + {1'b0, regfile_ff[alu_req.rr]};
            2'b01: nxt_alu = {1'b0, regfile_ff[alu_req.rd]} - {1'b0, regfile_ff[alu_req.rr]};
            2'b10: nxt_alu = {1'b0, regfile_ff[alu_req.rd] & regfile_ff[alu_req.rr]};
            2'b11: nxt_alu = {1'b0, regfile_ff[alu_req.rd] | regfile_ff[alu_req.rr]};
        endcase
    end

    // No reset on the file: it is storage, not control
    always_ff @(posedge pclk) begin
        if (clk_en && alu_req.valid) begin
            regfile_ff[alu_req.rd] <= nxt_alu[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alu_result <= 8'h00;
        end else if (clk_en && alu_req.valid) begin
            alu_result <= nxt_alu[7:0];
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Zero wait states; read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign apb_wr  = clk_en && psel && penable && pwrite;
    assign apb_rd  = clk_en && psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ctrl_ff <= `CIS_RST_CTRL;
            enable_ff    <= NSRC'(`CIS_RST_ENABLE);
            level_sel_ff <= NSRC'(`CIS_RST_LEVEL_SEL);
        end else if (apb_wr) begin
            if (paddr == `CIS_OFF_CORE_CTRL) begin
                core_ctrl_ff <= pwdata[2:0];
            end
            if (paddr == `CIS_OFF_ENABLE) begin
                enable_ff <= pwdata[NSRC-1:0];
            end
            if (paddr == `CIS_OFF_LEVEL_SEL) begin
                level_sel_ff <= pwdata[NSRC-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (clk_en && psel && !penable) begin
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            unique case (paddr)
                `CIS_OFF_CORE_CTRL: if (apb_rd) prdata <= {29'h0, core_ctrl_ff};
                `CIS_OFF_FLAGS_REG: if (apb_rd) prdata <= {24'h0, flags_reg_ff};
                `CIS_OFF_ENABLE:    if (apb_rd) prdata <= 32'(enable_ff);
                `CIS_OFF_IRQ_FLAGS: if (apb_rd) prdata <= 32'(irq_flag_ff);
                `CIS_OFF_LEVEL_SEL: if (apb_rd) prdata <= 32'(level_sel_ff);
                `CIS_OFF_STATUS:    if (apb_rd) prdata <= {16'h0, 8'(vec_idx_ff),
                                                           hold_one_ff, locked,
                                                           1'b0, cnt_ff, state_ff};
                `CIS_OFF_STACK_PTR: if (apb_rd) prdata <= {16'h0, sp_ff};
                default:            pslverr <= 1'b1;
            endcase
        end
    end

endmodule

// ---- test/cis_sequencer_chk.sv ----
`timescale 1ns/10ps
module cis_sequencer_chk
    import cis_pkg::*;
#(
    parameter logic [23:0] LOADER_BASE = 24'h00f000
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire cis_insn_s     insn,
    input wire cis_alu_s      alu_req,
    input wire cis_stack_s    stack_bus,
    input wire cis_redirect_s redirect,
    input wire logic          entry_busy,
    input wire logic [7:0]    alu_result,
    input wire logic [23:0]   reset_vector
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_alu_hold: assert property (!alu_req.valid |=> $stable(alu_result))
        else $error("alu result moved without a request");
    a_push_down: assert property (stack_bus.we && $past(stack_bus.we)
        |-> stack_bus.addr == $past(stack_bus.addr) - 16'h1) else $error("push not descending");
    a_pop_up: assert property (stack_bus.re && $past(stack_bus.re)
        |-> stack_bus.addr == $past(stack_bus.addr) + 16'h1) else $error("pop not ascending");
    a_stack_busy: assert property ((stack_bus.we || stack_bus.re) |-> entry_busy)
        else $error("stack access outside entry or return");
    a_cli_block: assert property (insn.global_disable_instruction && !insn.return_from_handler_instruction |=> !$rose(entry_busy))
        else $error("entry taken with global disable");
    a_idle_block: assert property ((insn.busy || !insn.retire) && !insn.sleeping
        && !insn.return_from_handler_instruction && !entry_busy |=> !$rose(entry_busy)) else $error("entry mid instruction");
    a_entry_len: assert property ($rose(entry_busy) && !insn.sleeping
        |-> ##[4:6] redirect.jump) else $error("jump not within five cycles");
    a_wake_len: assert property ($rose(entry_busy) && insn.sleeping
        |-> ##10 redirect.jump) else $error("wake entry not ten cycles");
    a_jump_once: assert property (redirect.jump |=> !redirect.jump)
        else $error("jump longer than one cycle");
    a_reset_vec: assert property (reset_vector == 24'h000000 || reset_vector == LOADER_BASE)
        else $error("reset vector off its two places");
endmodule

// ---- test/cis_stack_model.sv ----
`timescale 1ns/10ps
module cis_stack_model
    import cis_pkg::*;
(
    input  wire logic       pclk,
    input  wire cis_stack_s stack_bus,
    output logic [7:0]      stack_rdata
);
    logic [7:0] mem [int];

    initial stack_rdata = 8'h00;
    // Idle data toggles so a late sample of the byte never looks right
    always @(posedge pclk) begin
        if (stack_bus.we === 1'b1) begin
            mem[int'(stack_bus.addr)] = stack_bus.wdata;
        end
        if (stack_bus.re === 1'b1 && mem.exists(int'(stack_bus.addr))) begin
            stack_rdata <= mem[int'(stack_bus.addr)];
        end else begin
            stack_rdata <= ~stack_rdata;
        end
    end
endmodule

// ---- test/cis_sequencer_test.sv ----
`timescale 1ns/10ps
`include "cis_params.svh"
module cis_sequencer_test;
    import cis_pkg::*;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0;
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    logic [7:0]    src_event = 8'h00;
    logic [7:0]    src_level = 8'h00;
    cis_insn_s     insn = '0;
    logic [23:0]   pc_in = 24'h000000;
    logic [7:0]    stack_rdata;
    cis_stack_s    stack_bus;
    cis_redirect_s redirect;
    logic          entry_busy;
    logic [7:0]    alu_result;
    logic [23:0]   reset_vector;
    logic [31:0]   seed = 32'h5972be25;
    logic [31:0]   rd;
    logic          err;
    logic [15:0]   sp_m = 16'h10ff;
    logic [23:0]   push_q [$];
    logic [23:0]   jump_q [$];
    int            failures = 0;
    int            cmp_count = 0;

    always #25 pclk = ~pclk;

    cis_sequencer i_cis_sequencer (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .src_event(src_event), .src_level(src_level),
        .reset_vector_relocate_fuse(1'b0), .insn(insn), .pc_in(pc_in), .alu_req('0),
        .stack_rdata(stack_rdata), .stack_bus(stack_bus), .redirect(redirect),
        .entry_busy(entry_busy), .alu_result(alu_result), .reset_vector(reset_vector));
    cis_stack_model i_cis_stack_model (.pclk(pclk), .stack_bus(stack_bus),
        .stack_rdata(stack_rdata));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input logic [7:0] m, input logic c);
        @(posedge pclk);
        src_event <= m;
        insn.global_disable_instruction <= c;
        @(posedge pclk);
        src_event <= 8'h00;
        insn.global_disable_instruction <= 1'b0;
    endtask

    // Model of one entry: three pushed pc bytes, then the vector
    task automatic expect_entry(input int idx, input logic [23:0] base);
        push_q.push_back({sp_m, pc_in[7:0]});
        push_q.push_back({sp_m - 16'h1, pc_in[15:8]});
        push_q.push_back({sp_m - 16'h2, pc_in[23:16]});
        sp_m = sp_m - 16'h3;
        jump_q.push_back(base + 24'(2 * (idx + 1)));
    endtask

    task automatic return_from_handler_instruction_go;
        sp_m = sp_m + 16'h3;
        jump_q.push_back(pc_in);
        @(posedge pclk);
        insn.return_from_handler_instruction <= 1'b1;
        @(posedge pclk);
        while (insn.retire !== 1'b1) @(posedge pclk);
        insn.return_from_handler_instruction <= 1'b0;
    endtask

    task automatic settle;
        for (int i = 0; i < 60 && (push_q.size() + jump_q.size()) > 0; i++) @(posedge pclk);
        repeat (4) @(posedge pclk);
        chk(32'(push_q.size() + jump_q.size()), 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Monitor and random instruction flow
    // ----------------------------------------------------------------
    always @(posedge pclk) begin
        seed <= lfsr(seed);
        insn.retire <= seed[0];
        insn.busy <= ~seed[0] & seed[1];
        if (stack_bus.we === 1'b1) begin
            chk({8'h00, stack_bus.addr, stack_bus.wdata},
                push_q.size() > 0 ? {8'h00, push_q.pop_front()} : 32'hdeadbeef);
        end
        if (redirect.jump === 1'b1) begin
            chk({8'h00, redirect.target},
                jump_q.size() > 0 ? {8'h00, jump_q.pop_front()} : 32'hdeadbeef);
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        failures = failures + 1;
        complete_run;
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        pc_in <= {9'h000, seed[14:0]};
        apb(1'b0, `CIS_OFF_STACK_PTR, 32'h0);
        chk(rd, 32'h000010ff);
        chk({8'h00, reset_vector}, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `CIS_OFF_ENABLE, 32'h12);
        pulse(8'h12, 1'b0);
        apb(1'b0, `CIS_OFF_IRQ_FLAGS, 32'h0);
        chk(rd, 32'h12);
        expect_entry(1, 24'h0);
        apb(1'b1, `CIS_OFF_FLAGS_REG, 32'h80);
        settle;
        apb(1'b0, `CIS_OFF_FLAGS_REG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `CIS_OFF_IRQ_FLAGS, 32'h0);
        chk(rd, 32'h10);
        return_from_handler_instruction_go;
        expect_entry(4, 24'h0);
        settle;
        return_from_handler_instruction_go;
        settle;
        apb(1'b0, `CIS_OFF_FLAGS_REG, 32'h0);
        chk(rd, 32'h80);
        apb(1'b1, `CIS_OFF_ENABLE, 32'h0);
        pulse(8'h08, 1'b0);
        apb(1'b1, `CIS_OFF_IRQ_FLAGS, 32'h0);
        apb(1'b0, `CIS_OFF_IRQ_FLAGS, 32'h0);
        chk(rd, 32'h08);
        apb(1'b1, `CIS_OFF_IRQ_FLAGS, 32'h08);
        apb(1'b0, `CIS_OFF_IRQ_FLAGS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `CIS_OFF_ENABLE, 32'h01);
        pulse(8'h01, 1'b1);
        repeat (8) @(posedge pclk);
        apb(1'b0, `CIS_OFF_IRQ_FLAGS, 32'h0);
        chk(rd, 32'h01);
        apb(1'b1, `CIS_OFF_CORE_CTRL, 32'h3);
        apb(1'b1, `CIS_OFF_FLAGS_REG, 32'h80);
        repeat (8) @(posedge pclk);
        apb(1'b0, `CIS_OFF_IRQ_FLAGS, 32'h0);
        chk(rd, 32'h01);
        expect_entry(0, 24'h00f000);
        apb(1'b1, `CIS_OFF_CORE_CTRL, 32'h1);
        settle;
        return_from_handler_instruction_go;
        settle;
        // Level that vanishes before its enable must leave no trace
        src_level <= 8'h04;
        apb(1'b1, `CIS_OFF_LEVEL_SEL, 32'h04);
        src_level <= 8'h00;
        apb(1'b1, `CIS_OFF_ENABLE, 32'h04);
        repeat (8) @(posedge pclk);
        settle;
        expect_entry(2, 24'h00f000);
        src_level <= 8'h04;
        insn.sleeping <= 1'b1;
        settle;
        src_level <= 8'h00;
        insn.sleeping <= 1'b0;
        return_from_handler_instruction_go;
        settle;
        complete_run;
    end
endmodule

bind cis_sequencer cis_sequencer_chk #(.LOADER_BASE(LOADER_BASE)) i_cis_sequencer_chk (
    .pclk(pclk), .presetn(presetn), .insn(insn), .alu_req(alu_req), .stack_bus(stack_bus),
    .redirect(redirect), .entry_busy(entry_busy), .alu_result(alu_result),
    .reset_vector(reset_vector));
